// ===== dv/qsccs_client.sv
`timescale 1ns/1ps
module qsccs_client (
	input wire logic i_core_clk,
	output logic o_advert_load_strobe,
	output logic [15:0] o_advert_value_bus,
	output logic o_negotiation_restart_strobe
);
	initial begin
		o_advert_load_strobe = 1'b0;
		o_advert_value_bus = 16'h0000;
		o_negotiation_restart_strobe = 1'b0;
	end
	// Low for a cycle, then high with the value; bus inverted once sampled
	task automatic load_advert(input logic [15:0] v, input bit keep);
		@(posedge i_core_clk);
		o_advert_load_strobe <= 1'b0;
		@(posedge i_core_clk);
		o_advert_load_strobe <= 1'b1;
		o_advert_value_bus <= v;
		@(posedge i_core_clk);
		if (!keep) begin
			o_advert_load_strobe <= 1'b0;
		end
		o_advert_value_bus <= ~v;
	endtask
	// Leaves the strobe high on return
	task automatic restart();
		@(posedge i_core_clk);
		o_negotiation_restart_strobe <= 1'b0;
		@(posedge i_core_clk);
		o_negotiation_restart_strobe <= 1'b1;
	endtask
endmodule

// ===== dv/test_qsgmii_channel_config_status_vectors.sv
`timescale 1ns/1ps
module test_qsgmii_channel_config_status_vectors;
	logic clk, rst, psel, pen, pwr, rfe, phym, adv_stb, rst_stb;
	logic [7:0] paddr, pcs;
	logic [31:0] pwdata, prdata, rdata;
	logic pready, pslverr, rerr, an_en, an_rst, cen, rst_b, en_b;
	logic [1:0] rft;
	logic [15:0] lp, vec, adv, adv_val, adv_b;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;

	qsccs_top uut (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(cen),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_advert_load_strobe(adv_stb), .i_advert_value_bus(adv_val),
		.i_negotiation_restart_strobe(rst_stb), .i_sync_ok(pcs[1]), .i_rudi_c(pcs[2]),
		.i_rudi_i(pcs[3]), .i_rudi_invalid(pcs[4]), .i_disperr(pcs[5]),
		.i_notintable(pcs[6]), .i_phy_link(pcs[7]), .i_an_complete(pcs[0]),
		.i_phy_mode(phym), .i_rf_event(rfe), .i_rf_type(rft), .i_lp_ability(lp),
		.o_status_vector(vec), .o_advert_reg(adv), .o_an_enable(an_en),
		.o_an_restart(an_rst));
	// No management, no negotiation: strobes must do nothing here
	qsccs_top #(.HAS_MDIO(1'b0), .HAS_AN(1'b0)) uut_bare (.i_core_clk(clk), .i_sys_rst(rst),
		.i_clk_en(cen), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(), .o_pready(), .o_pslverr(),
		.i_advert_load_strobe(adv_stb), .i_advert_value_bus(adv_val),
		.i_negotiation_restart_strobe(rst_stb), .i_sync_ok(pcs[1]), .i_rudi_c(pcs[2]),
		.i_rudi_i(pcs[3]), .i_rudi_invalid(pcs[4]), .i_disperr(pcs[5]),
		.i_notintable(pcs[6]), .i_phy_link(pcs[7]), .i_an_complete(pcs[0]),
		.i_phy_mode(phym), .i_rf_event(rfe), .i_rf_type(rft), .i_lp_ability(lp),
		.o_status_vector(), .o_advert_reg(adv_b), .o_an_enable(en_b),
		.o_an_restart(rst_b));
	qsccs_client client (.i_core_clk(clk), .o_advert_load_strobe(adv_stb),
		.o_advert_value_bus(adv_val), .o_negotiation_restart_strobe(rst_stb));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic check_reset();
		settle(1);
		chk(32'(adv), 32'h0001);
		chk(32'(vec), 32'h0000);
		chk(32'(an_rst), 32'h0);
		chk(32'(en_b), 32'h0);
		apb(1'b0, qsccs_pkg::OFS_CTRL, 32'h0);
		chk(rdata, 32'h1000);
	endtask
	task automatic check_advert();
		client.load_advert(16'ha5c3, 1'b1);
		settle(1);
		chk(32'(adv), 32'ha5c3);
		chk(32'(adv_b), 32'h0001);
		// Strobe still high: the bus write must survive
		apb(1'b1, qsccs_pkg::OFS_ADV, 32'h1234);
		apb(1'b0, qsccs_pkg::OFS_ADV, 32'h0);
		chk(rdata, 32'h1234);
		client.load_advert(16'h5a3c, 1'b0);
		settle(1);
		chk(32'(adv), 32'h5a3c);
	endtask
	task automatic check_restart();
		repeat (2) begin
			client.restart();
			settle(2);
			chk(32'(an_rst), 32'h1);
			chk(32'(rst_b), 32'h0);
			settle(1);
			chk(32'(an_rst), 32'h0);
		end
		apb(1'b1, qsccs_pkg::OFS_CTRL, 32'h1200);
		settle(1);
		chk(32'(an_rst), 32'h1);
	endtask
	task automatic check_vector();
		logic [15:0] exp;
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				apb(1'b1, qsccs_pkg::OFS_CTRL, 32'h0);
			end
			for (int k = 0; k < 9; k++) begin
				@(posedge clk);
				pcs <= (k == 8) ? 8'h03 : 8'h01 << k;
				lp <= {3'h0, k[2], k[1:0], 1'b0, k[1:0], 7'h00};
				settle(2);
				exp = {lp[8:7], 1'b0, lp[12], lp[11:10], 2'b00, pcs[7:1], pcs[1] & (m == 1 || pcs[0])};
				chk(32'(vec), 32'(exp));
			end
		end
		chk(32'(an_en), 32'h0);
	endtask
	task automatic check_freeze();
		@(posedge clk);
		cen <= 1'b0;
		pcs <= 8'h80;
		settle(3);
		chk(32'(vec), 32'h0003);
		cen <= 1'b1;
		settle(2);
		chk(32'(vec), 32'h0080);
	endtask
	task automatic check_fault();
		apb(1'b1, qsccs_pkg::OFS_CTRL, 32'h1000);
		@(posedge clk);
		pcs <= 8'h00;
		lp <= 16'h0000;
		rft <= 2'h2;
		rfe <= 1'b1;
		@(posedge clk);
		rfe <= 1'b0;
		rft <= 2'h1;
		settle(8);
		chk(32'(vec), 32'h2200);
		apb(1'b0, qsccs_pkg::OFS_STAT, 32'h0);
		chk(32'(rdata[4]), 32'h1);
		settle(3);
		chk(32'(vec[13]), 32'h0);
		@(posedge clk);
		phym <= 1'b1;
		rft <= 2'h3;
		rfe <= 1'b1;
		@(posedge clk);
		rfe <= 1'b0;
		settle(4);
		chk(32'(vec), 32'h0000);
		apb(1'b0, 8'h3c, 32'h0);
		chk(rdata, 32'h0);
		chk(32'(rerr), 32'h1);
	endtask

	initial begin
		rst = 1'b1;
		{psel, pen, pwr, rfe, phym} = 5'h00;
		cen = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		pcs = 8'h00;
		rft = 2'h0;
		lp = 16'h0000;
		settle(3);
		rst <= 1'b0;
		check_reset();
		check_advert();
		check_restart();
		check_vector();
		check_freeze();
		check_fault();
		test_done();
	end
endmodule

// ===== hdl/qsccs_edge.sv
`timescale 1ns/1ps
module qsccs_edge #(
	parameter int W = 2
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic [W-1:0] i_level,
	output logic [W-1:0] o_rise
);
	logic [W-1:0] prev;

	// Held high through reset is not an edge
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			prev <= '1;
		end else if (i_clk_en) begin
			prev <= i_level;
		end
	end

	assign o_rise = i_level & ~prev;
endmodule

// ===== hdl/qsccs_pkg.sv
package qsccs_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_ADV = 8'h10;
	localparam logic [7:0] OFS_LPA = 8'h14;
	localparam logic [7:0] OFS_SVEC = 8'h40;
	// Control register fields
	localparam int CTRL_RESTART_BIT = 9;
	localparam int CTRL_AN_EN_BIT = 12;
	// Status register fields
	localparam int STAT_LINK_BIT = 2;
	localparam int STAT_RF_BIT = 4;
	localparam int STAT_AN_DONE_BIT = 5;
	// Partner ability fields
	localparam int LPA_PAUSE_LSB = 7;
	localparam int LPA_SPEED_LSB = 10;
	localparam int LPA_DUPLEX_BIT = 12;
	// Status vector fields
	localparam int SV_LINK = 0;
	localparam int SV_SYNC = 1;
	localparam int SV_RUDI_C = 2;
	localparam int SV_RUDI_I = 3;
	localparam int SV_RUDI_INV = 4;
	localparam int SV_DISPERR = 5;
	localparam int SV_NOTINTAB = 6;
	localparam int SV_PHY_LINK = 7;
	localparam int SV_RF_LSB = 8;
	localparam int SV_SPEED_LSB = 10;
	localparam int SV_DUPLEX = 12;
	localparam int SV_RF_FLAG = 13;
	localparam int SV_PAUSE_LSB = 14;
	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h1000;
	localparam logic [15:0] ADV_RST = 16'h0001;
	localparam logic [15:0] SVEC_RST = 16'h0000;
	localparam logic [1:0] RF_TYPE_RST = 2'h0;
endpackage

// ===== hdl/qsccs_stat_if.sv
`timescale 1ns/1ps
interface qsccs_stat_if;
	logic sync_ok;
	logic rudi_c;
	logic rudi_i;
	logic rudi_invalid;
	logic disperr;
	logic notintable;
	logic phy_link;
	logic an_complete;
	logic an_enable;
	logic phy_mode;
	logic rf_flag;
	logic [1:0] rf_type;
	logic [15:0] lp_ability;
	logic [15:0] vector;
	modport src(output sync_ok, rudi_c, rudi_i, rudi_invalid, disperr, notintable, phy_link,
		an_complete, an_enable, phy_mode, rf_flag, rf_type, lp_ability, input vector);
	modport sink(input sync_ok, rudi_c, rudi_i, rudi_invalid, disperr, notintable, phy_link,
		an_complete, an_enable, phy_mode, rf_flag, rf_type, lp_ability, output vector);
endinterface

// ===== hdl/qsccs_status.sv
`timescale 1ns/1ps
module qsccs_status #(
	parameter bit HAS_AN = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	qsccs_stat_if.sink stat
);
	logic [15:0] next_vector;
	logic an_on;

	always_comb begin
		an_on = HAS_AN & stat.an_enable;
		next_vector = qsccs_pkg::SVEC_RST;
		next_vector[qsccs_pkg::SV_LINK] = stat.sync_ok & (~an_on | stat.an_complete);
		next_vector[qsccs_pkg::SV_SYNC] = stat.sync_ok;
		next_vector[qsccs_pkg::SV_RUDI_C] = stat.rudi_c;
		next_vector[qsccs_pkg::SV_RUDI_I] = stat.rudi_i;
		next_vector[qsccs_pkg::SV_RUDI_INV] = stat.rudi_invalid;
		next_vector[qsccs_pkg::SV_DISPERR] = stat.disperr;
		next_vector[qsccs_pkg::SV_NOTINTAB] = stat.notintable;
		next_vector[qsccs_pkg::SV_PHY_LINK] = stat.phy_link;
		if (!stat.phy_mode) begin
			next_vector[qsccs_pkg::SV_RF_LSB +: 2] = stat.rf_type;
			next_vector[qsccs_pkg::SV_RF_FLAG] = stat.rf_flag;
		end
		next_vector[qsccs_pkg::SV_SPEED_LSB +: 2] =
			stat.lp_ability[qsccs_pkg::LPA_SPEED_LSB +: 2];
		next_vector[qsccs_pkg::SV_DUPLEX] = stat.lp_ability[qsccs_pkg::LPA_DUPLEX_BIT];
		next_vector[qsccs_pkg::SV_PAUSE_LSB +: 2] =
			stat.lp_ability[qsccs_pkg::LPA_PAUSE_LSB +: 2];
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			stat.vector <= qsccs_pkg::SVEC_RST;
		end else if (i_clk_en) begin
			stat.vector <= next_vector;
		end
	end
endmodule

// ===== hdl/qsccs_top.sv
`timescale 1ns/1ps
module qsccs_top #(
	parameter bit HAS_MDIO = 1'b1,
	parameter bit HAS_AN = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_advert_load_strobe,
	input wire logic [15:0] i_advert_value_bus,
	input wire logic i_negotiation_restart_strobe,
	input wire logic i_sync_ok,
	input wire logic i_rudi_c,
	input wire logic i_rudi_i,
	input wire logic i_rudi_invalid,
	input wire logic i_disperr,
	input wire logic i_notintable,
	input wire logic i_phy_link,
	input wire logic i_an_complete,
	input wire logic i_phy_mode,
	input wire logic i_rf_event,
	input wire logic [1:0] i_rf_type,
	input wire logic [15:0] i_lp_ability,
	output logic [15:0] o_status_vector,
	output logic [15:0] o_advert_reg,
	output logic o_an_enable,
	output logic o_an_restart
);
	logic [1:0] strobe_rise;
	logic [15:0] ctrl;
	logic [15:0] adv;
	logic restart;
	logic rf_flag;
	logic [1:0] rf_type;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic access;
	logic done;
	logic rd_hit;
	logic [31:0] rd_word;
	logic wr_ctrl;
	logic wr_adv;
	logic rd_stat;
	logic an_en;
	logic rf_set;
	logic an_en_out;

	qsccs_stat_if stat ();

	// Both strobes share the core clock, so no synchroniser
	qsccs_edge #(
		.W(2)
	) u_edge (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_level({i_negotiation_restart_strobe, i_advert_load_strobe}),
		.o_rise(strobe_rise)
	);

	qsccs_status #(
		.HAS_AN(HAS_AN)
	) u_status (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.stat(stat)
	);

	assign an_en = HAS_AN & ctrl[qsccs_pkg::CTRL_AN_EN_BIT];
	assign rf_set = i_rf_event & an_en & ~i_phy_mode;

	assign stat.sync_ok = i_sync_ok;
	assign stat.rudi_c = i_rudi_c;
	assign stat.rudi_i = i_rudi_i;
	assign stat.rudi_invalid = i_rudi_invalid;
	assign stat.disperr = i_disperr;
	assign stat.notintable = i_notintable;
	assign stat.phy_link = i_phy_link;
	assign stat.an_complete = i_an_complete;
	assign stat.an_enable = an_en;
	assign stat.phy_mode = i_phy_mode;
	assign stat.rf_flag = rf_flag;
	assign stat.rf_type = rf_type;
	assign stat.lp_ability = i_lp_ability;

	// APB: one wait state, commit on the edge that sees pready
	assign access = i_psel & i_penable;
	assign done = access & pready;
	assign wr_ctrl = done & i_pwrite & (i_paddr == qsccs_pkg::OFS_CTRL);
	assign wr_adv = done & i_pwrite & (i_paddr == qsccs_pkg::OFS_ADV);
	assign rd_stat = done & ~i_pwrite & (i_paddr == qsccs_pkg::OFS_STAT);

	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		case (i_paddr)
			qsccs_pkg::OFS_CTRL: begin
				rd_word[15:0] = ctrl;
				rd_word[qsccs_pkg::CTRL_RESTART_BIT] = restart;
			end
			qsccs_pkg::OFS_STAT: begin
				rd_word[qsccs_pkg::STAT_LINK_BIT] = stat.vector[qsccs_pkg::SV_LINK];
				rd_word[qsccs_pkg::STAT_RF_BIT] = rf_flag;
				rd_word[qsccs_pkg::STAT_AN_DONE_BIT] = i_an_complete;
			end
			qsccs_pkg::OFS_ADV: begin
				rd_word[15:0] = adv;
			end
			qsccs_pkg::OFS_LPA: begin
				rd_word[15:0] = i_lp_ability;
			end
			qsccs_pkg::OFS_SVEC: begin
				rd_word[15:0] = stat.vector;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			pready <= 1'b0;
		end else if (i_clk_en) begin
			pready <= access & ~pready;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (i_clk_en) begin
			if (access & ~pready) begin
				prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
				pslverr <= ~rd_hit;
			end else begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// Control word; restart bit lives in its own flop
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ctrl <= qsccs_pkg::CTRL_RST;
		end else if (i_clk_en && wr_ctrl) begin
			ctrl <= i_pwdata[15:0] & ~(16'h0001 << qsccs_pkg::CTRL_RESTART_BIT);
		end
	end

	// Restart self-clears after one cycle
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			restart <= 1'b0;
		end else if (i_clk_en) begin
			restart <= HAS_AN & (strobe_rise[1] |
				(wr_ctrl & i_pwdata[qsccs_pkg::CTRL_RESTART_BIT]));
		end
	end

	// Strobe load wins over a bus write in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			adv <= qsccs_pkg::ADV_RST;
		end else if (i_clk_en) begin
			if (HAS_MDIO && strobe_rise[0]) begin
				adv <= i_advert_value_bus;
			end else if (wr_adv) begin
				adv <= i_pwdata[15:0];
			end
		end
	end

	// Sticky fault; a new fault beats the clearing read
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rf_flag <= 1'b0;
		end else if (i_clk_en) begin
			if (rf_set) begin
				rf_flag <= 1'b1;
			end else if (rd_stat) begin
				rf_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rf_type <= qsccs_pkg::RF_TYPE_RST;
		end else if (i_clk_en && rf_set) begin
			rf_type <= i_rf_type;
		end
	end

	// Enable copy so the output leaves a flop with the option folded in
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			an_en_out <= HAS_AN & qsccs_pkg::CTRL_RST[qsccs_pkg::CTRL_AN_EN_BIT];
		end else if (i_clk_en && wr_ctrl) begin
			an_en_out <= HAS_AN & i_pwdata[qsccs_pkg::CTRL_AN_EN_BIT];
		end
	end

	assign o_prdata = prdata;
	assign o_pready = pready;
	assign o_pslverr = pslverr;
	assign o_status_vector = stat.vector;
	assign o_advert_reg = adv;
	assign o_an_enable = an_en_out;
	assign o_an_restart = restart;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence adv_rise_s;
		HAS_MDIO && i_clk_en && strobe_rise[0];
	endsequence

	sequence restart_rise_s;
		HAS_AN && i_clk_en && strobe_rise[1];
	endsequence

	sequence fault_held_s;
		i_clk_en && rf_flag && !rd_stat;
	endsequence

	sequence held_advert_s;
		i_clk_en && i_advert_load_strobe && !wr_adv ##1
			i_clk_en && i_advert_load_strobe && !wr_adv;
	endsequence

	sequence held_restart_s;
		i_clk_en && i_negotiation_restart_strobe && !wr_ctrl ##1
			i_clk_en && i_negotiation_restart_strobe && !wr_ctrl;
	endsequence

	adv_load_a: assert property (adv_rise_s |=> o_advert_reg == $past(i_advert_value_bus))
		else $error("advert register missed strobe load");
	adv_ignore_a: assert property ((!HAS_MDIO && !wr_adv) |=> $stable(o_advert_reg))
		else $error("advert register changed without management");
	restart_set_a: assert property (restart_rise_s |=> o_an_restart)
		else $error("restart bit not set on strobe edge");
	restart_gate_a: assert property (!HAS_AN |-> !o_an_restart)
		else $error("restart raised without negotiation");
	link_bit_a: assert property (i_clk_en |=> o_status_vector[0] ==
		($past(i_sync_ok) && (!$past(an_en) || $past(i_an_complete))))
		else $error("link status bit wrong");
	link_mirror_a: assert property ($past(i_clk_en) && !$past(an_en) |->
		o_status_vector[0] == o_status_vector[1])
		else $error("link bit differs from sync bit");
	sync_bit_a: assert property (i_clk_en |=> o_status_vector[1] == $past(i_sync_ok))
		else $error("sync bit does not follow sync state");
	rudi_bits_a: assert property (i_clk_en |=> o_status_vector[4:2] ==
		$past({i_rudi_invalid, i_rudi_i, i_rudi_c}))
		else $error("ordered set bits wrong");
	code_err_a: assert property (i_clk_en |=> o_status_vector[6:5] ==
		$past({i_notintable, i_disperr}))
		else $error("decode error bits wrong");
	fault_sticky_a: assert property (fault_held_s |=> rf_flag ##1 (rf_flag || rd_stat ||
		!$past(i_clk_en) || $past(rd_stat)))
		else $error("remote fault flag dropped early");
	fault_clear_a: assert property ((i_clk_en && rd_stat && !rf_set) |=> !rf_flag)
		else $error("remote fault flag not cleared by read");
	speed_pause_a: assert property (i_clk_en |=> {o_status_vector[15:14],
		o_status_vector[11:10]} == {$past(i_lp_ability[8:7]), $past(i_lp_ability[11:10])})
		else $error("pause or speed bits do not mirror partner ability");

	// A strobe held high acts once, not every cycle
	adv_held_a: assert property (held_advert_s |=> $stable(o_advert_reg))
		else $error("advert register reloaded by a held strobe");
	restart_held_a: assert property (held_restart_s |=> !o_an_restart)
		else $error("restart repeated by a held strobe");
	restart_bus_a: assert property ((HAS_AN && i_clk_en && wr_ctrl &&
		i_pwdata[qsccs_pkg::CTRL_RESTART_BIT]) |=> o_an_restart)
		else $error("restart bit write did not pulse restart");

	// Loose status bits, one cycle behind their inputs
	rudi_idle_a: assert property (i_clk_en |=> o_status_vector[3] == $past(i_rudi_i))
		else $error("idle set bit wrong");
	rudi_inval_a: assert property (i_clk_en |=> o_status_vector[4] == $past(i_rudi_invalid))
		else $error("invalid data bit wrong");
	not_table_a: assert property (i_clk_en |=> o_status_vector[6] == $past(i_notintable))
		else $error("code table bit wrong");
	phy_link_a: assert property (i_clk_en |=> o_status_vector[7] == $past(i_phy_link))
		else $error("phy link bit wrong");
	speed_bits_a: assert property (i_clk_en |=> o_status_vector[11:10] == $past(i_lp_ability[11:10]))
		else $error("speed bits wrong");
	duplex_bit_a: assert property (i_clk_en |=> o_status_vector[12] == $past(i_lp_ability[12]))
		else $error("duplex bit wrong");

	// Remote fault fields, blanked in PHY mode
	fault_code_a: assert property (i_clk_en && !i_phy_mode |=> o_status_vector[9:8] == $past(rf_type))
		else $error("remote fault type bits wrong");
	fault_phy_a: assert property (i_clk_en && i_phy_mode |=>
		o_status_vector[9:8] == 2'b00 && !o_status_vector[13])
		else $error("remote fault shown in phy mode");
	fault_set_a: assert property ((i_clk_en && rf_set) |=> rf_flag)
		else $error("remote fault flag not set");
	fault_flag_a: assert property (i_clk_en && !i_phy_mode |=> o_status_vector[13] == $past(rf_flag))
		else $error("remote fault bit does not follow flag");

	// Enable low freezes every output
	freeze_all_a: assert property (!i_clk_en |=> $stable(o_status_vector) &&
		$stable(o_advert_reg) && $stable(o_an_restart) && $stable(o_an_enable) &&
		$stable(o_pready) && $stable(o_prdata))
		else $error("state moved while clock enable low");
endmodule
